// *** verilog/pcicc_top.sv ***
// Command control register and the bus behaviour it gates
`timescale 1ns/10ps
`include "pcicc_regs.svh"
module pcicc_top #(
  parameter int PAL_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cfg_valid,
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_offset,
  input wire pcicc_pkg::pcicc_cbe_t i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  output pcicc_pkg::pcicc_word_t o_command,
  input wire logic i_tgt_start,
  input wire pcicc_pkg::pcicc_cbe_t i_tgt_cmd,
  input wire logic i_tgt_hit,
  input wire logic i_tgt_palette,
  output logic o_tgt_claim,
  input wire logic i_pal_data_valid,
  input wire logic [PAL_W-1:0] i_pal_data,
  output logic o_snoop_valid,
  output logic [PAL_W-1:0] o_snoop_data,
  input wire logic i_addr_par_err,
  input wire logic i_data_par_err,
  output logic o_serr_out,
  output logic o_serr_oe_n,
  output logic o_perr_out,
  output logic o_perr_oe_n,
  input wire logic i_mst_req,
  input wire pcicc_pkg::pcicc_cbe_t i_mst_cmd,
  input wire logic i_gnt_n,
  output logic o_req_n,
  output logic o_mst_own,
  output pcicc_pkg::pcicc_cbe_t o_mst_cmd,
  output logic o_fast_b2b,
  output logic o_stepping
);
  import pcicc_pkg::*;

  pcicc_state_t state_r;
  pcicc_state_t state_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic take;
  logic hit;
  logic we_lo;
  logic we_hi;
  logic [7:0] cmd_lo;
  logic [7:0] cmd_hi;
  pcicc_word_t command;
  logic claim_r;
  logic claim_nxt;
  logic is_mem;
  logic is_io;
  logic is_pal_wr;
  logic req_n_r;
  logic req_n_nxt;
  logic own_r;
  logic own_nxt;
  pcicc_cbe_t mcmd_r;
  pcicc_cbe_t mcmd_nxt;
  logic zero_r;
  logic zero_nxt;
  logic system_error_enable;
  logic pre_en;
  logic snoop_en;
  logic bme;
  logic mem_en;
  logic io_en;

  assign command = {cmd_hi, cmd_lo};
  assign system_error_enable = command[`PCICC_SERR_BIT];
  assign pre_en = command[`PCICC_PRE_BIT];
  assign snoop_en = command[`PCICC_SNOOP_BIT];
  assign bme = command[`PCICC_BME_BIT];
  assign mem_en = command[`PCICC_MEM_BIT];
  assign io_en = command[`PCICC_IO_BIT];

  // Access decode; a new access is only taken while idle
  assign take = (state_r == PCICC_IDLE) & i_cfg_valid;
  assign hit = ({i_cfg_offset[7:2], 2'b00} == `PCICC_CMD_OFFSET);

  assign we_lo = take & i_cfg_write & hit & i_cfg_be[0];
  assign we_hi = take & i_cfg_write & hit & i_cfg_be[1];

  // Config handshake: answer one cycle after the access is taken
  always_comb begin
    state_nxt = state_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      PCICC_IDLE: begin
        if (i_cfg_valid) begin
          state_nxt = PCICC_DONE;
          ack_nxt = 1'b1;
          // Status half is outside this block and reads zero here
          rdata_nxt = (hit & ~i_cfg_write) ? {16'h0000, command} : 32'h0;
        end
      end
      PCICC_DONE: begin
        state_nxt = PCICC_IDLE;
      end
      default: begin
        state_nxt = PCICC_IDLE;
      end
    endcase
  end

  // Config handshake registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= PCICC_IDLE;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // mask keeps reserved and fixed bits at zero
  pcicc_lane #(
    .W(8),
    .MASK(`PCICC_WMASK_LO),
    .RST(`PCICC_RST_LO)
  ) u_lane_lo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_we(we_lo),
    .i_wdata(i_cfg_wdata[7:0]),
    .o_q(cmd_lo)
  );

  // fast back-to-back and reserved bits excluded by mask
  pcicc_lane #(
    .W(8),
    .MASK(`PCICC_WMASK_HI),
    .RST(`PCICC_RST_HI)
  ) u_lane_hi (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_we(we_hi),
    .i_wdata(i_cfg_wdata[15:8]),
    .o_q(cmd_hi)
  );

  // Target command classes; special cycles fall in neither class
  always_comb begin
    is_mem = (i_tgt_cmd == `PCICC_CMD_MEMRD) |
             (i_tgt_cmd == `PCICC_CMD_MEMWR) |
             (i_tgt_cmd == `PCICC_CMD_MRM) |
             (i_tgt_cmd == `PCICC_CMD_MRL) |
             (i_tgt_cmd == `PCICC_CMD_MWI);
    is_io = (i_tgt_cmd == `PCICC_CMD_IORD) |
            (i_tgt_cmd == `PCICC_CMD_IOWR);
    is_pal_wr = i_tgt_palette & ((i_tgt_cmd == `PCICC_CMD_IOWR) |
                (i_tgt_cmd == `PCICC_CMD_MEMWR) |
                (i_tgt_cmd == `PCICC_CMD_MWI));
  end

  // snooped palette writes left to the real owner
  always_comb begin
    claim_nxt = i_tgt_start & i_tgt_hit &
                ((is_mem & mem_en) | (is_io & io_en)) &
                ~(is_pal_wr & snoop_en);
  end

  // request and ownership gated by master enable
  // write-and-invalidate issued as plain memory write
  always_comb begin
    req_n_nxt = ~(i_mst_req & bme);
    own_nxt = i_mst_req & bme & ~i_gnt_n;
    mcmd_nxt = (i_mst_cmd == `PCICC_CMD_MWI) ? `PCICC_CMD_MEMWR : i_mst_cmd;
    zero_nxt = 1'b0;
  end

  // Target and initiator registers; zero_r holds fixed low outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      claim_r <= 1'b0;
      req_n_r <= 1'b1;
      own_r <= 1'b0;
      mcmd_r <= 4'h0;
      zero_r <= 1'b0;
    end else begin
      claim_r <= claim_nxt;
      req_n_r <= req_n_nxt;
      own_r <= own_nxt;
      mcmd_r <= mcmd_nxt;
      zero_r <= zero_nxt;
    end
  end

  // address parity to SERR needs both enables
  pcicc_qual #(
    .W(1),
    .ACT_LOW(1'b1)
  ) u_serr (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_addr_par_err),
    .i_enable(system_error_enable & pre_en),
    .i_data(1'b0),
    .o_fire(o_serr_oe_n),
    .o_data()
  );

  // data parity to PERR only with response on
  pcicc_qual #(
    .W(1),
    .ACT_LOW(1'b1)
  ) u_perr (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_data_par_err),
    .i_enable(pre_en),
    .i_data(1'b0),
    .o_fire(o_perr_oe_n),
    .o_data()
  );

  pcicc_qual #(
    .W(PAL_W),
    .ACT_LOW(1'b0)
  ) u_snoop (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_pal_data_valid),
    .i_enable(snoop_en),
    .i_data(i_pal_data),
    .o_fire(o_snoop_valid),
    .o_data(o_snoop_data)
  );

  assign o_cfg_ack = ack_r;
  assign o_cfg_rdata = rdata_r;
  assign o_command = command;
  assign o_tgt_claim = claim_r;
  assign o_req_n = req_n_r;
  assign o_mst_own = own_r;
  assign o_mst_cmd = mcmd_r;
  assign o_fast_b2b = zero_r;
  assign o_stepping = zero_r;
  // Open-drain pins only ever pull low
  assign o_serr_out = zero_r;
  assign o_perr_out = zero_r;

  // Checks on the register image and the gated behaviour
  property p_reserved;
    @(posedge i_clock) disable iff (i_rst)
    (o_command[15:10] == 6'h00) && (o_cfg_rdata[15:10] == 6'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved command bits not zero");

  property p_b2b;
    @(posedge i_clock) disable iff (i_rst)
    !o_command[`PCICC_B2B_BIT] && !o_fast_b2b && !o_cfg_rdata[9];
  endproperty
  a_b2b: assert property (p_b2b)
    else $error("fast back-to-back shown or used");

  property p_serr_off;
    @(posedge i_clock) disable iff (i_rst)
    !$past(system_error_enable) |-> o_serr_oe_n;
  endproperty
  a_serr_off: assert property (p_serr_off)
    else $error("system error driven while disabled");

  property p_serr_cause;
    @(posedge i_clock) disable iff (i_rst)
    i_addr_par_err && system_error_enable && pre_en |=>
      !o_serr_oe_n ##1 (o_serr_oe_n || $past(i_addr_par_err));
  endproperty
  a_serr_cause: assert property (p_serr_cause)
    else $error("address parity error not reported");

  property p_serr_needs_pre;
    @(posedge i_clock) disable iff (i_rst)
    !o_serr_oe_n |-> $past(i_addr_par_err) && $past(pre_en);
  endproperty
  a_serr_needs_pre: assert property (p_serr_needs_pre)
    else $error("system error without parity response enable");

  property p_step;
    @(posedge i_clock) disable iff (i_rst)
    !o_command[`PCICC_STEP_BIT] && !o_stepping;
  endproperty
  a_step: assert property (p_step)
    else $error("stepping bit set or used");

  property p_perr;
    @(posedge i_clock) disable iff (i_rst)
    !o_perr_oe_n |-> $past(i_data_par_err) && $past(pre_en);
  endproperty
  a_perr: assert property (p_perr)
    else $error("parity error driven without cause or enable");

  property p_perr_fire;
    @(posedge i_clock) disable iff (i_rst)
    i_data_par_err && pre_en |=> !o_perr_oe_n;
  endproperty
  a_perr_fire: assert property (p_perr_fire)
    else $error("data parity error not signalled");

  property p_snoop;
    @(posedge i_clock) disable iff (i_rst)
    i_tgt_start && is_pal_wr && snoop_en |=> !o_tgt_claim;
  endproperty
  a_snoop: assert property (p_snoop)
    else $error("snooped palette write was claimed");

  property p_mwi;
    @(posedge i_clock) disable iff (i_rst)
    (o_mst_cmd != `PCICC_CMD_MWI) && !o_command[`PCICC_MWI_BIT];
  endproperty
  a_mwi: assert property (p_mwi)
    else $error("write-and-invalidate issued");

  property p_special;
    @(posedge i_clock) disable iff (i_rst)
    i_tgt_cmd == `PCICC_CMD_SPECIAL |=> !o_tgt_claim;
  endproperty
  a_special: assert property (p_special)
    else $error("special cycle claimed");

  property p_req;
    @(posedge i_clock) disable iff (i_rst)
    (!o_req_n || o_mst_own) |-> $past(bme) && $past(i_mst_req);
  endproperty
  a_req: assert property (p_req)
    else $error("bus requested without master enable");

  property p_mem;
    @(posedge i_clock) disable iff (i_rst)
    o_tgt_claim && $past(is_mem) |-> $past(mem_en);
  endproperty
  a_mem: assert property (p_mem)
    else $error("memory cycle claimed while disabled");

  property p_io;
    @(posedge i_clock) disable iff (i_rst)
    o_tgt_claim && $past(is_io) |-> $past(io_en);
  endproperty
  a_io: assert property (p_io)
    else $error("io cycle claimed while disabled");

  property p_lanes;
    @(posedge i_clock) disable iff (i_rst)
    take && !(i_cfg_write && hit && i_cfg_be[0]) |=>
      $stable(o_command[7:0]);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("low lane changed without enabled write");

  property p_ack;
    @(posedge i_clock) disable iff (i_rst)
    take |=> o_cfg_ack ##1 !o_cfg_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("configuration answer not one cycle");
endmodule

// *** verilog/pcicc_regs.svh ***
// Offsets, field positions, reset values and command codes of the block
// Summary of operation
// - Bits 15 to 10 of the control register read as zero and ignore writes.
// - Bit 9 reads as zero and no fast back-to-back transfer is started.
// - Bit 8 enables the system error driver; it resets to zero (off).
// - Address parity errors reach the system error pin only with 8 and 6 set.
// - Bit 7 is wired to zero and address/data stepping is never used.
// - Bit 6 enables parity error response; at zero errors are ignored.
// - With response on, data parity errors drive PERR, address ones SERR if bit 8 is set.
// - With bit 5 set palette writes are not claimed but their data is copied.
// - Bit 4 is wired to zero; write-and-invalidate becomes a memory write.
// - Bit 3 is wired to zero and special cycles are never answered.
// - Bit 2 gates bus requests and bus ownership; it resets to zero.
// - Bit 1 gates claiming of memory space cycles; it resets to zero.
// - Bit 0 gates claiming of I/O space cycles; it resets to zero.
`ifndef PCICC_REGS_SVH
`define PCICC_REGS_SVH
`define PCICC_CMD_OFFSET 8'h04
`define PCICC_WMASK_LO 8'h67
`define PCICC_WMASK_HI 8'h01
`define PCICC_RST_LO 8'h00
`define PCICC_RST_HI 8'h00
`define PCICC_IO_BIT 0
`define PCICC_MEM_BIT 1
`define PCICC_BME_BIT 2
`define PCICC_SPC_BIT 3
`define PCICC_MWI_BIT 4
`define PCICC_SNOOP_BIT 5
`define PCICC_PRE_BIT 6
`define PCICC_STEP_BIT 7
`define PCICC_SERR_BIT 8
`define PCICC_B2B_BIT 9
`define PCICC_CMD_SPECIAL 4'h1
`define PCICC_CMD_IORD 4'h2
`define PCICC_CMD_IOWR 4'h3
`define PCICC_CMD_MEMRD 4'h6
`define PCICC_CMD_MEMWR 4'h7
`define PCICC_CMD_MRM 4'hc
`define PCICC_CMD_MRL 4'he
`define PCICC_CMD_MWI 4'hf
`endif

// *** verilog/pcicc_pkg.sv ***
// Types shared by the command control block
package pcicc_pkg;
  typedef enum logic [0:0] {
    PCICC_IDLE = 1'b0,
    PCICC_DONE = 1'b1
  } pcicc_state_t;
  typedef logic [3:0] pcicc_cbe_t;
  typedef logic [15:0] pcicc_word_t;
endpackage

// *** verilog/pcicc_lane.sv ***
// One byte lane of the control register with a writable-bit mask
`timescale 1ns/10ps
module pcicc_lane #(
  parameter int W = 8,
  parameter logic [W-1:0] MASK = '0,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Fixed bits load zero on every write, matching their zero reset
  always_comb begin
    q_nxt = i_we ? (i_wdata & MASK) : q_r;
  end

  // Lane storage
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule

// *** verilog/pcicc_qual.sv ***
// Enable-qualified registered strobe with optional captured data
`timescale 1ns/10ps
module pcicc_qual #(
  parameter int W = 1,
  parameter logic ACT_LOW = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_event,
  input wire logic i_enable,
  input wire logic [W-1:0] i_data,
  output logic o_fire,
  output logic [W-1:0] o_data
);
  logic fire_r;
  logic fire_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;

  // Strobe only when the gating bit is on; data held between strobes
  always_comb begin
    fire_nxt = (i_event & i_enable) ^ ACT_LOW;
    data_nxt = (i_event & i_enable) ? i_data : data_r;
  end

  // Strobe and data registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fire_r <= ACT_LOW;
      data_r <= '0;
    end else begin
      fire_r <= fire_nxt;
      data_r <= data_nxt;
    end
  end

  assign o_fire = fire_r;
  assign o_data = data_r;
endmodule

// *** bench/pcicc_host.sv ***
// Configuration software model driving the register access port
`timescale 1ns/10ps
module pcicc_host (
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  output logic o_valid,
  output logic o_write,
  output logic [7:0] o_offset,
  output pcicc_pkg::pcicc_cbe_t o_be,
  output logic [31:0] o_wdata
);
  import pcicc_pkg::*;
  logic seen;
  // Idle bus before the first access
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_offset = 8'h00;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end
  task automatic access(input logic wr, input logic [7:0] off,
      input pcicc_cbe_t be, input logic [31:0] wd,
      output logic [31:0] rd);
    seen = 1'b0;
    @(posedge i_clock);
    #1;
    o_valid = 1'b1;
    o_write = wr;
    o_offset = off;
    o_be = be;
    o_wdata = wd;
    for (int n = 0; n < 8 && seen !== 1'b1; n++) begin
      @(posedge i_clock);
      seen = i_ack;
    end
    rd = i_rdata;
    #1;
    o_valid = 1'b0;
    // Released lines carry junk so stale values cannot pass
    o_write = ~wr;
    o_offset = ~off;
    o_be = ~be;
    o_wdata = ~wd;
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the command control block
`timescale 1ns/10ps
module testbench;
  import pcicc_pkg::*;
  logic i_clock, i_rst, i_cfg_valid, i_cfg_write, o_cfg_ack;
  logic [7:0] i_cfg_offset, i_pal_data, o_snoop_data;
  pcicc_cbe_t i_cfg_be, i_tgt_cmd, i_mst_cmd, o_mst_cmd;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, rd;
  pcicc_word_t o_command, exp_cmd;
  logic i_tgt_start, i_tgt_hit, i_tgt_palette, o_tgt_claim;
  logic i_pal_data_valid, o_snoop_valid, i_addr_par_err, i_data_par_err;
  logic o_serr_out, o_serr_oe_n, o_perr_out, o_perr_oe_n;
  logic i_mst_req, i_gnt_n, o_req_n, o_mst_own, o_fast_b2b, o_stepping;
  int miscompares, total_checks;
  logic [3:0] cmds [8] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};
  pcicc_word_t cfgs [5] = '{16'h0000, 16'h0003, 16'h0023, 16'h0001,
    16'h0002};
  pcicc_word_t errs [4] = '{16'h0040, 16'h0100, 16'h0140, 16'h0020};

  pcicc_top #(.PAL_W(8)) u_pcicc_top (.i_clock, .i_rst, .i_cfg_valid,
    .i_cfg_write, .i_cfg_offset, .i_cfg_be, .i_cfg_wdata, .o_cfg_ack,
    .o_cfg_rdata, .o_command, .i_tgt_start, .i_tgt_cmd, .i_tgt_hit,
    .i_tgt_palette, .o_tgt_claim, .i_pal_data_valid, .i_pal_data,
    .o_snoop_valid, .o_snoop_data, .i_addr_par_err, .i_data_par_err,
    .o_serr_out, .o_serr_oe_n, .o_perr_out, .o_perr_oe_n, .i_mst_req,
    .i_mst_cmd, .i_gnt_n, .o_req_n, .o_mst_own, .o_mst_cmd, .o_fast_b2b,
    .o_stepping);

  pcicc_host u_pcicc_host (.i_clock, .i_ack(o_cfg_ack),
    .i_rdata(o_cfg_rdata), .o_valid(i_cfg_valid), .o_write(i_cfg_write),
    .o_offset(i_cfg_offset), .o_be(i_cfg_be), .o_wdata(i_cfg_wdata));

  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Write with lane enables, then check the live image
  task automatic wrc(input pcicc_cbe_t be, input logic [7:0] off,
      input pcicc_word_t v, input pcicc_word_t e);
    u_pcicc_host.access(1'b1, off, be, {16'h0, v}, rd);
    exp_cmd = e;
    chk(u_pcicc_host.seen, 1'b1);
    chk(o_command, e);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] e);
    u_pcicc_host.access(1'b0, off, 4'hf, 32'h0, rd);
    chk(u_pcicc_host.seen, 1'b1);
    chk(rd, e);
  endtask

  // One target address phase; claim expected from the enables
  task automatic tgt(input logic [3:0] c, input logic hit, input logic pal);
    logic ex;
    ex = hit & ((c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}) & exp_cmd[1]
      | (c inside {4'h2, 4'h3}) & exp_cmd[0])
      & ~(pal & (c inside {4'h3, 4'h7, 4'hf}) & exp_cmd[5]);
    @(posedge i_clock);
    #1;
    i_tgt_start = 1'b1;
    i_tgt_cmd = c;
    i_tgt_hit = hit;
    i_tgt_palette = pal;
    @(posedge i_clock);
    #1;
    i_tgt_start = 1'b0;
    i_tgt_hit = ~hit;
    chk(o_tgt_claim, ex);
  endtask

  // Errors, palette data and a master request in the same cycle
  task automatic misc();
    @(posedge i_clock);
    #1;
    i_addr_par_err = 1'b1;
    i_data_par_err = 1'b1;
    i_pal_data_valid = 1'b1;
    i_pal_data = 8'h5a;
    i_mst_req = 1'b1;
    i_mst_cmd = 4'hf;
    i_gnt_n = 1'b0;
    @(posedge i_clock);
    #1;
    {i_addr_par_err, i_data_par_err, i_pal_data_valid, i_mst_req} = 4'h0;
    i_gnt_n = 1'b1;
    i_pal_data = 8'ha5;
    // Non-remapped command must pass through unchanged
    i_mst_cmd = 4'h6;
    chk(o_serr_oe_n, !(exp_cmd[8] && exp_cmd[6]));
    chk(o_perr_oe_n, !exp_cmd[6]);
    chk({o_serr_out, o_perr_out}, 2'b00);
    chk(o_snoop_valid, exp_cmd[5]);
    if (exp_cmd[5]) chk(o_snoop_data, 8'h5a);
    chk({o_req_n, o_mst_own}, {~exp_cmd[2], exp_cmd[2]});
    chk(o_mst_cmd, 4'h7);
    chk({o_fast_b2b, o_stepping}, 2'b00);
    @(posedge i_clock);
    #1;
    chk({o_serr_oe_n, o_perr_oe_n, o_req_n}, 3'b111);
    chk(o_mst_cmd, 4'h6);
    chk(o_snoop_valid, 1'b0);
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1;
    {i_tgt_start, i_tgt_hit, i_tgt_palette, i_pal_data_valid} = 4'h0;
    {i_addr_par_err, i_data_par_err, i_mst_req} = 3'h0;
    i_tgt_cmd = 4'h0;
    i_mst_cmd = 4'h0;
    i_pal_data = 8'h00;
    i_gnt_n = 1'b1;
    exp_cmd = 16'h0000;
    repeat (4) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    chk(o_command, 16'h0000);
    rdc(8'h04, 32'h0);
    misc();
    done("reset");
    wrc(4'hf, 8'h04, 16'hffff, 16'h0167);
    rdc(8'h04, 32'h0000_0167);
    misc();
    done("hardwired");
    wrc(4'h1, 8'h04, 16'h0000, 16'h0100);
    wrc(4'h2, 8'h04, 16'h0000, 16'h0000);
    wrc(4'hc, 8'h04, 16'hffff, 16'h0000);
    wrc(4'h2, 8'h04, 16'hffff, 16'h0100);
    wrc(4'h3, 8'h08, 16'hffff, 16'h0100);
    rdc(8'h08, 32'h0);
    rdc(8'h04, 32'h0000_0100);
    done("lanes");
    foreach (errs[i]) begin
      wrc(4'h3, 8'h04, errs[i], errs[i]);
      misc();
    end
    done("errors");
    foreach (cfgs[i]) begin
      wrc(4'h3, 8'h04, cfgs[i], cfgs[i]);
      foreach (cmds[k]) begin
        tgt(cmds[k], 1'b1, 1'b0);
        tgt(cmds[k], 1'b1, 1'b1);
      end
      tgt(4'h6, 1'b0, 1'b0);
    end
    done("target");
    summarize();
  end

  // Watchdog far beyond the expected run length
  initial begin
    #50000;
    miscompares++;
    $display("watchdog expired");
    summarize();
  end
endmodule
